// ---- hw/sarc_top.sv ----
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module sarc_top #(
    parameter int CONV_CLKS = 10
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // register port
    input wire sarc_pkg::sarc_bus_t bus_i,
    output logic [7:0] rdata_o,
    // trigger sources
    input wire logic tmr3_ovf_i,
    input wire logic tmr2_ovf_i,
    input wire logic other_busy_wr_i,
    input wire logic external_convert_start_i,
    // chip power state, analog side and interrupt
    input wire logic standby_i,
    input wire logic [7:0] result_i,
    output logic track_o,
    output logic convert_o,
    output logic conv_tick_o,
    output logic irq_o
);
    import sarc_pkg::*;

    if (CONV_CLKS < 1 || CONV_CLKS > 63) begin : g_conv_range
        $error("CONV_CLKS out of range");
    end

    localparam logic [5:0] CONV_LAST = 6'(CONV_CLKS - 1);
    localparam logic [5:0] TRACK_LAST = 6'(TRACK_CLKS - 1);

    // trigger decode for the selected source
    function automatic logic start_hit(input logic [2:0] m, input logic sw,
        input logic t3, input logic ex, input logic t2, input logic sh);
        logic h;
        h = 1'b0;
        if (m[2]) begin
            h = sh;
        end else begin
            unique case (m[1:0])
                2'b00: h = sw;
                2'b01: h = t3;
                2'b10: h = ex;
                2'b11: h = t2;
            endcase
        end
        return h;
    endfunction : start_hit

    logic [7:0] ctrl_reg, ctrl_next;
    logic [4:0] div_reg, div_next;
    logic [7:0] res_reg, res_next;
    logic [7:0] stat_reg, stat_next;
    logic [7:0] mask_reg, mask_next;
    logic [7:0] rdata_reg, rdata_next;
    logic irq_reg, irq_next;
    logic [4:0] dcnt_reg, dcnt_next;
    logic tick_reg, tick_next;
    logic ex_s1_reg, ex_s2_reg, ex_d_reg;
    sarc_state_t st_reg, st_next;
    logic [5:0] cnt_reg, cnt_next;
    logic trk_reg, trk_next;
    logic cv_reg, cv_next;
    logic busy, ext_mode, ext_rise, sw_go, start_evt, start_acc, done_pls;
    logic wr_ctrl;

    assign busy = (st_reg != ST_IDLE);
    assign ext_mode = (ctrl_reg[4:2] == SM_EXT);
    // the first sync stage feeds only the second
    assign ext_rise = ex_s2_reg & ~ex_d_reg;
    assign wr_ctrl = bus_i.wr && (bus_i.addr == ADDR_CTRL);
    assign sw_go = wr_ctrl && bus_i.wdata[CTRL_BUSY];

    assign start_evt = start_hit(ctrl_reg[4:2], sw_go, tmr3_ovf_i, ext_rise,
        tmr2_ovf_i, other_busy_wr_i);
    assign start_acc = start_evt && !busy;

    // pin synchroniser plus edge history
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ex_s1_reg <= 1'b0;
            ex_s2_reg <= 1'b0;
            ex_d_reg <= 1'b0;
        end else begin
            ex_s1_reg <= external_convert_start_i;
            ex_s2_reg <= ex_s1_reg;
            ex_d_reg <= ex_s2_reg;
        end
    end

    // divider, restarted on each accepted start
    // so the tracking window is whole conversion clocks
    always_comb begin
        dcnt_next = dcnt_reg + 5'h01;
        tick_next = 1'b0;
        if (start_acc) begin
            dcnt_next = 5'h00;
        end else if (dcnt_reg >= div_reg) begin
            dcnt_next = 5'h00;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            dcnt_reg <= 5'h00;
            tick_reg <= 1'b0;
        end else begin
            dcnt_reg <= dcnt_next;
            tick_reg <= tick_next;
        end
    end

    // conversion sequencer
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        done_pls = 1'b0;
        unique case (st_reg)
            ST_IDLE: begin
                if (start_acc) begin
                    cnt_next = 6'h00;
                    if (ctrl_reg[CTRL_TM] && !ext_mode) begin
                        st_next = ST_TRACK;
                    end else begin
                        st_next = ST_CONV;
                    end
                end
            end
            ST_TRACK: begin
                if (tick_reg) begin
                    cnt_next = cnt_reg + 6'h01;
                    if (cnt_reg == TRACK_LAST) begin
                        st_next = ST_CONV;
                        cnt_next = 6'h00;
                    end
                end
            end
            ST_CONV: begin
                if (tick_reg) begin
                    cnt_next = cnt_reg + 6'h01;
                    if (cnt_reg == CONV_LAST) begin
                        st_next = ST_IDLE;
                        done_pls = 1'b1;
                    end
                end
            end
            default: begin
                st_next = ST_IDLE;
                cnt_next = 6'h00;
            end
        endcase
        trk_next = !standby_i && (st_next != ST_CONV) &&
            ((st_next == ST_TRACK) || !ctrl_reg[CTRL_TM] ||
            (ext_mode && !ex_s2_reg));
        cv_next = (st_next == ST_CONV);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_reg <= ST_IDLE;
            cnt_reg <= 6'h00;
            trk_reg <= 1'b0;
            cv_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            trk_reg <= trk_next;
            cv_reg <= cv_next;
        end
    end

    // register file; hardware set wins over clear
    always_comb begin
        ctrl_next = ctrl_reg;
        div_next = div_reg;
        res_next = res_reg;
        mask_next = mask_reg;
        stat_next = stat_reg;
        rdata_next = 8'h00;
        if (wr_ctrl) begin
            ctrl_next = {2'b00, bus_i.wdata[5:1], 1'b0};
        end
        if (bus_i.wr && bus_i.addr == ADDR_CFG) begin
            div_next = bus_i.wdata[7:CFG_DIV_LO];
        end
        if (bus_i.wr && bus_i.addr == ADDR_MASK) begin
            mask_next = {6'h00, bus_i.wdata[1:0]};
        end
        if (bus_i.wr && bus_i.addr == ADDR_STAT) begin
            stat_next = stat_reg & ~bus_i.wdata;
        end
        // done flag and status on busy fall
        if (done_pls) begin
            ctrl_next[CTRL_DONE] = 1'b1;
            stat_next[STAT_DONE] = 1'b1;
            res_next = result_i;
        end
        if (start_evt && busy) begin
            stat_next[STAT_OVR] = 1'b1;
        end
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                ADDR_CTRL: rdata_next = ctrl_reg | {7'h00, busy};
                ADDR_CFG: rdata_next = {div_reg, 2'b00, div_reg < DIV_FIELD_MIN};
                ADDR_RES: rdata_next = res_reg;
                ADDR_STAT: rdata_next = stat_reg;
                ADDR_MASK: rdata_next = mask_reg;
                default: rdata_next = 8'h00;
            endcase
        end
        irq_next = |(stat_reg & mask_reg);
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ctrl_reg <= CTRL_RST;
            div_reg <= DIV_RST;
            res_reg <= 8'h00;
            stat_reg <= 8'h00;
            mask_reg <= MASK_RST;
            rdata_reg <= 8'h00;
            irq_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            div_reg <= div_next;
            res_reg <= res_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
        end
    end
    assign rdata_o = rdata_reg;
    assign irq_o = irq_reg;
    assign track_o = trk_reg;
    assign convert_o = cv_reg;
    assign conv_tick_o = tick_reg;
    // helper: clocks since last tick, clean-interval flag, tracking ticks
    logic [5:0] gap_reg;
    logic gap_ok_reg;
    logic [2:0] ttk_reg;
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            gap_reg <= 6'h00;
            gap_ok_reg <= 1'b0;
            ttk_reg <= 3'h0;
        end else begin
            gap_reg <= (tick_reg || start_acc) ? 6'h01 : gap_reg + 6'h01;
            gap_ok_reg <= (start_acc || bus_i.wr) ? 1'b0 : (tick_reg || gap_ok_reg);
            ttk_reg <= (st_reg != ST_TRACK) ? 3'h0 : ttk_reg + 3'(tick_reg);
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    a_div_period: assert property (
        tick_reg && gap_ok_reg && $stable(div_reg) |-> gap_reg == {1'b0, div_reg} + 6'h01)
        else $error("conversion clock period wrong");
    a_sw_start: assert property (
        ctrl_reg[4:2] == SM_SW && sw_go && !busy && !ctrl_reg[CTRL_TM] |=> st_reg == ST_CONV)
        else $error("software start missed");
    a_t3_start: assert property (
        ctrl_reg[4:2] == SM_T3 && tmr3_ovf_i && !busy |=> busy)
        else $error("timer 3 start missed");
    a_ext_start: assert property (
        ext_mode && $rose(ex_s2_reg) && !busy |=> st_reg == ST_CONV)
        else $error("external start missed");
    a_t2_start: assert property (
        ctrl_reg[4:2] == SM_T2 && tmr2_ovf_i && !busy |=> busy)
        else $error("timer 2 start missed");
    a_shared_start: assert property (
        ctrl_reg[4] && other_busy_wr_i && !busy |=> busy)
        else $error("shared start missed");
    a_done_flag: assert property (
        $fell(busy) && $past(rst_b_i) |-> ctrl_reg[CTRL_DONE] && stat_reg[STAT_DONE] ##1
        (irq_reg || !$past(mask_reg[STAT_DONE])))
        else $error("done flag or interrupt wrong");
    a_result_cap: assert property (
        $fell(busy) && $past(rst_b_i) |-> res_reg == $past(result_i))
        else $error("result not captured");
    a_track_conv: assert property (
        st_reg == ST_CONV |-> !track_o ##1 !track_o || st_reg != ST_CONV)
        else $error("tracking during conversion");
    a_track_len: assert property (
        st_reg == ST_TRACK && st_next == ST_CONV |-> ttk_reg == 3'(TRACK_CLKS - 1))
        else $error("tracking window length wrong");
    a_standby: assert property (
        standby_i |=> !track_o)
        else $error("tracking in standby");
    a_busy_ignore: assert property (
        busy && start_evt && st_reg == ST_CONV && !tick_reg |=> st_reg == ST_CONV
        && stat_reg[STAT_OVR])
        else $error("trigger not ignored while busy");
    c_sw_conv: cover property (sw_go && !busy ##[1:1000] $fell(busy));
    c_lp_track: cover property (st_reg == ST_TRACK ##1 st_reg == ST_CONV);
    c_overrun: cover property (busy && start_evt);
    c_ext_lp: cover property (ctrl_reg[CTRL_TM] && ext_mode && track_o ##1 ext_rise);
endmodule : sarc_top

// ---- inc/sarc_pkg.sv ----
package sarc_pkg;
    // register index on the plain port
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_CFG = 3'h1;
    localparam logic [2:0] ADDR_RES = 3'h2;
    localparam logic [2:0] ADDR_STAT = 3'h3;
    localparam logic [2:0] ADDR_MASK = 3'h4;
    // control register fields
    localparam int CTRL_BUSY = 0;
    localparam int CTRL_DONE = 1;
    localparam int CTRL_MODE_LO = 2;
    localparam int CTRL_TM = 5;
    // config register fields
    localparam int CFG_FAST = 0;
    localparam int CFG_DIV_LO = 3;
    // status and mask bits
    localparam int STAT_DONE = 0;
    localparam int STAT_OVR = 1;
    // values after reset
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [4:0] DIV_RST = 5'h1f;
    localparam logic [7:0] MASK_RST = 8'h00;
    // timing
    localparam int TRACK_CLKS = 3;
    localparam longint SYS_CLK_HZ = 125000000;
    localparam longint SAR_FMAX_HZ = 6000000;
    localparam int DIV_MIN = int'((SYS_CLK_HZ + SAR_FMAX_HZ - 1) / SAR_FMAX_HZ);
    localparam logic [4:0] DIV_FIELD_MIN = 5'(DIV_MIN - 1);
    // start-of-conversion sources, 1xx all mean shared start
    typedef enum logic [2:0] {
        SM_SW = 3'b000,
        SM_T3 = 3'b001,
        SM_EXT = 3'b010,
        SM_T2 = 3'b011
    } sarc_mode_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TRACK = 2'b01,
        ST_CONV = 2'b10
    } sarc_state_t;
    // register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sarc_bus_t;
endpackage : sarc_pkg

// ---- verification/sarc_top_test.sv ----
`timescale 1ns/10ps
module sarc_top_test;
    import sarc_pkg::*;
    // short conversions keep the run brief
    localparam int CONV_N = 4;
    typedef struct packed {
        logic [2:0] mode;
        logic tm;
        logic [4:0] div;
        logic [2:0] src;
        logic [7:0] res;
    } sarc_row_t;
    // design ports, all driven from time zero
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    sarc_bus_t bus_i = '0;
    logic [7:0] rdata_o;
    logic tmr3_ovf_i = 1'b0;
    logic tmr2_ovf_i = 1'b0;
    logic other_busy_wr_i = 1'b0;
    logic external_convert_start_i = 1'b0;
    logic standby_i = 1'b0;
    logic [7:0] result_i = 8'h00;
    logic track_o, convert_o, conv_tick_o, irq_o;
    // bookkeeping
    int fails = 0;
    int checks_done = 0;
    int n_tot, n_high, n_tick, n_trk, exp_n;
    logic [7:0] rd_val, ctl;
    sarc_row_t r;
    // src: 0 software, 1 timer 3, 2 pin, 3 timer 2, 4 shared start
    // dividers of 20 and up keep the conversion clock at or below 6 MHz
    sarc_row_t rows [10] = '{
        '{SM_SW, 1'b0, 5'h14, 3'h0, 8'h5a}, '{SM_T3, 1'b0, 5'h15, 3'h1, 8'ha5},
        '{SM_EXT, 1'b0, 5'h14, 3'h2, 8'h3c}, '{SM_T2, 1'b1, 5'h14, 3'h3, 8'hc3},
        '{3'b100, 1'b0, 5'h14, 3'h4, 8'h11}, '{3'b101, 1'b0, 5'h16, 3'h4, 8'h0f},
        '{3'b110, 1'b0, 5'h18, 3'h4, 8'h22}, '{3'b111, 1'b1, 5'h1f, 3'h4, 8'hf0},
        '{SM_EXT, 1'b1, 5'h17, 3'h2, 8'h81}, '{SM_SW, 1'b1, 5'h19, 3'h0, 8'h7e}
    };
    logic [7:0] rst_exp [6] = '{CTRL_RST, {DIV_RST, 3'b000}, 8'h00, 8'h00, MASK_RST, 8'h00};
    logic [4:0] divs [4] = '{5'd18, 5'd19, 5'd20, 5'd31};

    sarc_top #(.CONV_CLKS(CONV_N)) dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .tmr3_ovf_i(tmr3_ovf_i), .tmr2_ovf_i(tmr2_ovf_i), .other_busy_wr_i(other_busy_wr_i),
        .external_convert_start_i(external_convert_start_i), .standby_i(standby_i),
        .result_i(result_i), .track_o(track_o), .convert_o(convert_o),
        .conv_tick_o(conv_tick_o), .irq_o(irq_o)
    );

    // 125 MHz system clock
    initial begin
        forever #4 clk_i = ~clk_i;
    end

    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one-cycle register write, taken at the second edge
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_i <= '0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task rd(input logic [2:0] a);
        @(posedge clk_i);
        bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_i <= '0;
        #1 rd_val = rdata_o;
    endtask : rd

    // returns at the edge where the trigger is sampled
    task trig(input logic [2:0] src, input logic [7:0] c);
        case (src)
            3'd0: wr(ADDR_CTRL, c);
            3'd1: begin
                @(posedge clk_i) tmr3_ovf_i <= 1'b1;
                @(posedge clk_i) tmr3_ovf_i <= 1'b0;
            end
            3'd2: begin
                @(posedge clk_i) external_convert_start_i <= 1'b1;
                // two sync stages plus the edge register
                repeat (3) @(posedge clk_i);
            end
            3'd3: begin
                @(posedge clk_i) tmr2_ovf_i <= 1'b1;
                @(posedge clk_i) tmr2_ovf_i <= 1'b0;
            end
            default: begin
                @(posedge clk_i) other_busy_wr_i <= 1'b1;
                @(posedge clk_i) other_busy_wr_i <= 1'b0;
            end
        endcase
    endtask : trig

    // edges until convert_o falls, bounded so a stuck converter cannot hang us
    task measure;
        n_tot = 0;
        n_high = 0;
        n_tick = 0;
        n_trk = 0;
        while (n_tot < 2000 && !(n_high > 0 && convert_o === 1'b0)) begin
            @(posedge clk_i);
            #1 n_tot++;
            if (convert_o === 1'b1) begin
                n_high++;
                n_tick += int'(conv_tick_o === 1'b1);
                n_trk += int'(track_o !== 1'b0);
            end
        end
    endtask : measure

    task results;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    // watchdog, well beyond the expected run
    initial begin
        #400000;
        fails++;
        results();
    end

    // main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        wr(ADDR_MASK, 8'h01);
        foreach (rows[i]) begin
            r = rows[i];
            ctl = {2'b00, r.tm, r.mode, 2'b00};
            wr(ADDR_CFG, {r.div, 3'b000});
            wr(ADDR_CTRL, ctl);
            result_i <= r.res;
            repeat (3) @(posedge clk_i);
            #1 if (r.tm && r.src == 3'd2) chk("track_pin_low", 16'h1, track_o);
            trig(r.src, ctl | 8'h01);
            measure();
            exp_n = CONV_N * (int'(r.div) + 1);
            chk("conv_cycles", exp_n, n_high);
            chk("conv_ticks", CONV_N, n_tick);
            chk("track_in_conv", 16'h0, n_trk);
            // the pin start in low-power mode has no extra tracking window
            exp_n = exp_n + 1 + ((r.tm && r.src != 3'd2) ? 3 * (int'(r.div) + 1) : 0);
            chk("latency", exp_n, n_tot);
            @(posedge clk_i) external_convert_start_i <= 1'b0;
            rd(ADDR_CTRL);
            chk("ctrl_done", ctl | 8'h02, rd_val);
            chk("irq_done", 16'h1, irq_o);
            rd(ADDR_RES);
            chk("result", r.res, rd_val);
            wr(ADDR_STAT, 8'h01);
            rd(ADDR_STAT);
            chk("status_clear", 16'h0, rd_val);
            chk("irq_clear", 16'h0, irq_o);
            if (!r.tm) chk("track_idle", 16'h1, track_o);
        end
        // retrigger while busy is ignored and flagged
        wr(ADDR_MASK, 8'h02);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_CTRL, 8'h01);
        wr(ADDR_CTRL, 8'h01);
        measure();
        // measuring starts two edges after the accepted start
        chk("ignored_retrigger", CONV_N * (int'(r.div) + 1) - 2, n_high);
        rd(ADDR_STAT);
        chk("status_overrun", 16'h3, rd_val);
        chk("irq_overrun", 16'h1, irq_o);
        wr(ADDR_STAT, 8'h02);
        rd(ADDR_STAT);
        chk("status_partial", 16'h1, rd_val);
        chk("irq_masked", 16'h0, irq_o);
        wr(ADDR_STAT, 8'h01);
        // divider limit flag is read-only
        foreach (divs[i]) begin
            wr(ADDR_CFG, {divs[i], 3'b001});
            rd(ADDR_CFG);
            chk("cfg_flag", {divs[i], 2'b00, divs[i] < DIV_FIELD_MIN}, rd_val);
        end
        // standby stops tracking
        @(posedge clk_i) standby_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1 chk("track_standby", 16'h0, track_o);
        @(posedge clk_i) standby_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1 chk("track_resume", 16'h1, track_o);
        // reset in mid-conversion restores every register
        wr(ADDR_CTRL, 8'h01);
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        #1 chk("reset_convert", 16'h0, convert_o);
        chk("reset_irq", 16'h0, irq_o);
        for (int a = 0; a < 6; a++) begin
            rd(3'(a));
            chk("reset_value", rst_exp[a], rd_val);
        end
        chk("reset_track", 16'h1, track_o);
        results();
    end
endmodule : sarc_top_test
